// [mag_regs_pkg.sv]
// Register map, field layout and timing constants of the sensor host port
package mag_regs_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_X_HI      = 8'h00;
    localparam logic [7:0] ADDR_X_MID     = 8'h01;
    localparam logic [7:0] ADDR_Y_HI      = 8'h02;
    localparam logic [7:0] ADDR_Y_MID     = 8'h03;
    localparam logic [7:0] ADDR_Z_HI      = 8'h04;
    localparam logic [7:0] ADDR_Z_MID     = 8'h05;
    localparam logic [7:0] ADDR_LOW_BITS  = 8'h06;
    localparam logic [7:0] ADDR_TEMP      = 8'h07;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_CTL_A     = 8'h09;
    localparam logic [7:0] ADDR_CTL_B     = 8'h0A;
    localparam logic [7:0] ADDR_CTL_C     = 8'h0B;
    localparam logic [7:0] ADDR_CTL_D     = 8'h0C;
    localparam logic [7:0] ADDR_PART_ID   = 8'h2F;

    // ==========================================================
    // Read image slots for addresses outside the 00H..0CH run
    localparam logic [3:0] IDX_PART_ID    = 4'hD;
    localparam logic [3:0] IDX_NONE       = 4'hF;

    // ==========================================================
    // Field positions and reset values
    localparam int         STAT_MEAS_M    = 0;
    localparam int         STAT_MEAS_T    = 1;
    localparam int         STAT_OTP       = 4;
    localparam int         CTLA_TM_M      = 0;
    localparam int         CTLA_TM_T      = 1;
    localparam int         CTLA_INT_EN    = 2;
    localparam logic [1:0] BW_16BIT       = 2'h0;
    localparam logic [7:0] CTL_RESET      = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    // Arbitrary identity and bus address values
    localparam logic [7:0] PART_ID_DEFAULT  = 8'h5A;
    localparam logic [6:0] SLAVE_ADDR_DFLT  = 7'h30;

    // ==========================================================
    // Timing
    localparam int         CORE_CLK_HZ    = 20_000_000;
    localparam int         MEAS_TIME_MS   = 10;
    localparam int         MEAS_CYC_DFLT  = (MEAS_TIME_MS * CORE_CLK_HZ) / 1000;

    // ==========================================================
    // State types
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_RX, I_WACK, I_TX, I_MACK
    } i2c_state_t;

    typedef enum logic [1:0] {
        MS_IDLE, MS_MAG, MS_TEMP
    } meas_state_t;

endpackage : mag_regs_pkg

// [mag_host_regs.sv]
// Host register interface: I2C slave, four-wire serial port, register map
`timescale 1ns/1ns
module mag_host_regs
    import mag_regs_pkg::*;
#(
    parameter int         MEAS_CYC   = MEAS_CYC_DFLT,
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DFLT,
    parameter logic [7:0] PART_ID    = PART_ID_DEFAULT
) (
    // Core clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Serial link pins
    input  wire logic        SCL_SCK,
    input  wire logic        CHIP_SELECT_N,
    input  wire logic        SERIAL_IN_LINE,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic             SERIAL_OUT_LINE,
    // Event pin
    output logic             INT_O,
    output logic             INT_OE,
    // Sensor front end results
    input  wire logic [17:0] X_RESULT,
    input  wire logic [17:0] Y_RESULT,
    input  wire logic [17:0] Z_RESULT,
    input  wire logic [7:0]  TEMP_RESULT
);

    function automatic logic [3:0] map_idx(input logic [7:0] a);
        if (a <= ADDR_CTL_D)
            map_idx = a[3:0];
        else if (a == ADDR_PART_ID)
            map_idx = IDX_PART_ID;
        else
            map_idx = IDX_NONE;
    endfunction : map_idx

    // ==========================================================
    // Pin synchronisers
    logic [2:0]  scl_q, sda_q, cs_q, wtg_q;
    logic        scl_st_r, sda_st_r, cs_st_r, scl_prev_r, sda_prev_r;
    logic        wtg_seen_r, swtgl_r;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            cs_q  <= 3'h7;
            wtg_q <= 3'h0;
        end else begin
            scl_q <= {scl_q[1:0], SCL_SCK};
            sda_q <= {sda_q[1:0], SERIAL_IN_LINE};
            cs_q  <= {cs_q[1:0], CHIP_SELECT_N};
            wtg_q <= {wtg_q[1:0], swtgl_r};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_st_r   <= 1'b1;
            sda_st_r   <= 1'b1;
            cs_st_r    <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            if (scl_q[1] == scl_q[2]) scl_st_r <= scl_q[2];
            if (sda_q[1] == sda_q[2]) sda_st_r <= sda_q[2];
            if (cs_q[1] == cs_q[2]) cs_st_r <= cs_q[2];
            scl_prev_r <= scl_st_r;
            sda_prev_r <= sda_st_r;
        end
    end

    logic i2c_on, scl_rise, scl_fall, i2c_start, i2c_stop, wev;
    assign i2c_on    = cs_st_r;
    assign scl_rise  = scl_st_r & ~scl_prev_r;
    assign scl_fall  = ~scl_st_r & scl_prev_r;
    assign i2c_start = scl_st_r & scl_prev_r & sda_prev_r & ~sda_st_r;
    assign i2c_stop  = scl_st_r & scl_prev_r & ~sda_prev_r & sda_st_r;
    assign wev       = (wtg_q[1] == wtg_q[2]) && (wtg_q[2] != wtg_seen_r);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            wtg_seen_r <= 1'b0;
        else if (wev)
            wtg_seen_r <= wtg_q[2];
    end

    // ==========================================================
    // Register state and read image
    logic [17:0] x_r, y_r, z_r;
    logic [7:0]  t_r, ctl_a_r, ctl_b_r, ctl_c_r, ctl_d_r;
    logic        m_done_r, t_done_r, otp_r;
    logic [7:0]  img [16];
    logic [7:0]  snap_r [16];

    always_comb begin
        for (int i = 0; i < 16; i++)
            img[i] = BYTE_ZERO;
        img[ADDR_X_HI[3:0]]     = x_r[17:10];
        img[ADDR_X_MID[3:0]]    = x_r[9:2];
        img[ADDR_Y_HI[3:0]]     = y_r[17:10];
        img[ADDR_Y_MID[3:0]]    = y_r[9:2];
        img[ADDR_Z_HI[3:0]]     = z_r[17:10];
        img[ADDR_Z_MID[3:0]]    = z_r[9:2];
        img[ADDR_LOW_BITS[3:0]] = {x_r[1:0], y_r[1:0], z_r[1:0], 2'h0};
        img[ADDR_TEMP[3:0]]     = t_r;
        img[ADDR_STATUS[3:0]]   = {3'h0, otp_r, 2'h0, t_done_r, m_done_r};
        img[IDX_PART_ID]        = PART_ID;
    end

    // Serial reads use a copy frozen during a frame; it is quasi-static
    // for the link domain, but it keeps taking register changes for up to
    // four core cycles after chip select falls.
    genvar g;
    for (g = 0; g < 16; g++) begin : g_snap
        always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N)
                snap_r[g] <= BYTE_ZERO;
            else if (cs_st_r)
                snap_r[g] <= img[g];
        end
    end

    // ==========================================================
    // Shared write port
    i2c_state_t  i2c_st_r;
    logic [3:0]  ibit_r;
    logic [7:0]  ish_r, itx_r, iptr_r;
    logic        irw_r, ifirst_r, inack_r, sda_oe_r, sda_o_r;
    logic [5:0]  swa_r;
    logic [7:0]  swd_r;
    logic        wr_en, i2c_wr, stat_w1c;
    logic [7:0]  wr_addr, wr_data, i2c_next;

    assign i2c_wr = i2c_on & scl_fall & (i2c_st_r == I_RX)
                    & (ibit_r == 4'h8) & ~ifirst_r;
    assign i2c_next = iptr_r + 8'h01;

    always_comb begin
        wr_en   = 1'b0;
        wr_addr = iptr_r;
        wr_data = ish_r;
        if (wev) begin
            wr_en   = 1'b1;
            wr_addr = {2'h0, swa_r};
            wr_data = swd_r;
        end else if (i2c_wr) begin
            wr_en   = 1'b1;
        end
    end
    assign stat_w1c = wr_en && (wr_addr == ADDR_STATUS);

    // ==========================================================
    // Measurement sequencing
    meas_state_t ms_r;
    logic [27:0] mcnt_r, meas_lim;
    logic        m_start, t_start, m_end, t_end, bw16;

    // Other bandwidth codes halve the time per step
    assign meas_lim = 28'(MEAS_CYC >> ctl_b_r[1:0]);
    assign bw16     = (ctl_b_r[1:0] == BW_16BIT);
    assign m_start  = (ms_r == MS_IDLE) & ctl_a_r[CTLA_TM_M];
    assign t_start  = (ms_r == MS_IDLE) & ~ctl_a_r[CTLA_TM_M]
                      & ctl_a_r[CTLA_TM_T];
    assign m_end    = (ms_r == MS_MAG) && (mcnt_r == meas_lim - 28'h1);
    assign t_end    = (ms_r == MS_TEMP) && (mcnt_r == meas_lim - 28'h1);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_r   <= MS_IDLE;
            mcnt_r <= '0;
        end else begin
            unique case (ms_r)
                MS_IDLE: begin
                    mcnt_r <= '0;
                    if (m_start) ms_r <= MS_MAG;
                    else if (t_start) ms_r <= MS_TEMP;
                end
                MS_MAG, MS_TEMP: begin
                    mcnt_r <= mcnt_r + 28'h1;
                    if (m_end || t_end) ms_r <= MS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            x_r <= '0;
            y_r <= '0;
            z_r <= '0;
            t_r <= BYTE_ZERO;
        end else if (m_end) begin
            // 16-bit mode leaves the two packed low bits at zero
            x_r <= bw16 ? {X_RESULT[17:2], 2'h0} : X_RESULT;
            y_r <= bw16 ? {Y_RESULT[17:2], 2'h0} : Y_RESULT;
            z_r <= bw16 ? {Z_RESULT[17:2], 2'h0} : Z_RESULT;
        end else if (t_end) begin
            t_r <= TEMP_RESULT;
        end
    end

    // ==========================================================
    // Status and control registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            m_done_r <= 1'b0;
            t_done_r <= 1'b0;
            otp_r    <= 1'b0;
        end else begin
            otp_r <= 1'b1;
            // Completion wins over a clear in the same cycle
            if (m_end)
                m_done_r <= 1'b1;
            else if (m_start || (stat_w1c && wr_data[STAT_MEAS_M]))
                m_done_r <= 1'b0;
            if (t_end)
                t_done_r <= 1'b1;
            else if (t_start || (stat_w1c && wr_data[STAT_MEAS_T]))
                t_done_r <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_a_r <= CTL_RESET;
            ctl_b_r <= CTL_RESET;
            ctl_c_r <= CTL_RESET;
            ctl_d_r <= CTL_RESET;
        end else begin
            if (wr_en && wr_addr == ADDR_CTL_A) begin
                ctl_a_r <= wr_data;
                // Both triggers at once: magnetic wins, temperature dropped
                if (wr_data[CTLA_TM_M]) ctl_a_r[CTLA_TM_T] <= 1'b0;
            end else if (m_end) begin
                ctl_a_r[CTLA_TM_M] <= 1'b0;
            end else if (t_end) begin
                ctl_a_r[CTLA_TM_T] <= 1'b0;
            end
            if (wr_en && wr_addr == ADDR_CTL_B) ctl_b_r <= wr_data;
            if (wr_en && wr_addr == ADDR_CTL_C) ctl_c_r <= wr_data;
            if (wr_en && wr_addr == ADDR_CTL_D) ctl_d_r <= wr_data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            INT_O  <= 1'b0;
            INT_OE <= 1'b0;
        end else begin
            INT_O  <= ctl_a_r[CTLA_INT_EN] & (m_done_r | t_done_r);
            INT_OE <= ctl_a_r[CTLA_INT_EN];
        end
    end

    // ==========================================================
    // I2C slave, oversampled on the core clock
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            i2c_st_r <= I_IDLE;
            ibit_r   <= 4'h0;
            ish_r    <= BYTE_ZERO;
            itx_r    <= BYTE_ZERO;
            iptr_r   <= BYTE_ZERO;
            irw_r    <= 1'b0;
            ifirst_r <= 1'b0;
            inack_r  <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (!i2c_on) begin
            i2c_st_r <= I_IDLE;
            sda_oe_r <= 1'b0;
        end else if (i2c_start) begin
            i2c_st_r <= I_ADDR;
            ibit_r   <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (i2c_stop) begin
            i2c_st_r <= I_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (i2c_st_r)
                I_IDLE: ;
                I_ADDR, I_RX: begin
                    if (scl_rise) begin
                        ish_r  <= {ish_r[6:0], sda_st_r};
                        ibit_r <= ibit_r + 4'h1;
                    end else if (scl_fall && ibit_r == 4'h8) begin
                        if (i2c_st_r == I_RX) begin
                            sda_oe_r <= 1'b1;
                            i2c_st_r <= I_WACK;
                            iptr_r   <= ifirst_r ? ish_r : i2c_next;
                        end else if (ish_r[7:1] == SLAVE_ADDR) begin
                            sda_oe_r <= 1'b1;
                            irw_r    <= ish_r[0];
                            i2c_st_r <= I_AACK;
                        end else begin
                            i2c_st_r <= I_IDLE;
                        end
                    end
                end
                I_AACK: if (scl_fall) begin
                    ibit_r <= 4'h0;
                    if (irw_r) begin
                        itx_r    <= img[map_idx(iptr_r)];
                        sda_oe_r <= ~img[map_idx(iptr_r)][7];
                        i2c_st_r <= I_TX;
                    end else begin
                        ifirst_r <= 1'b1;
                        sda_oe_r <= 1'b0;
                        i2c_st_r <= I_RX;
                    end
                end
                I_WACK: if (scl_fall) begin
                    sda_oe_r <= 1'b0;
                    ibit_r   <= 4'h0;
                    ifirst_r <= 1'b0;
                    i2c_st_r <= I_RX;
                end
                I_TX: begin
                    if (scl_rise) begin
                        ibit_r <= ibit_r + 4'h1;
                    end else if (scl_fall) begin
                        if (ibit_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            i2c_st_r <= I_MACK;
                        end else begin
                            sda_oe_r <= ~itx_r[3'h7 - ibit_r[2:0]];
                        end
                    end
                end
                I_MACK: begin
                    if (scl_rise) begin
                        inack_r <= sda_st_r;
                    end else if (scl_fall) begin
                        if (inack_r) begin
                            i2c_st_r <= I_IDLE;
                        end else begin
                            iptr_r   <= i2c_next;
                            itx_r    <= img[map_idx(i2c_next)];
                            sda_oe_r <= ~img[map_idx(i2c_next)][7];
                            ibit_r   <= 4'h0;
                            i2c_st_r <= I_TX;
                        end
                    end
                end
            endcase
        end
    end

    // Open drain: only a low level is ever driven
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            sda_o_r <= 1'b0;
        else
            sda_o_r <= 1'b0;
    end
    assign SDA_O  = sda_o_r;
    assign SDA_OE = sda_oe_r;

    // ==========================================================
    // Four-wire serial port on the link clock
    logic        spi_clr_n, scmd_r, srw_r;
    logic [2:0]  sbit_r;
    logic [5:0]  saddr_r;
    logic [6:0]  ssh_r;
    logic        post_wr;

    // Chip select high holds the frame logic cleared between frames
    assign spi_clr_n = RST_N & ~CHIP_SELECT_N;
    assign post_wr   = scmd_r & ~srw_r & (sbit_r == 3'h7);

    always_ff @(posedge SCL_SCK or negedge spi_clr_n) begin
        if (!spi_clr_n) begin
            scmd_r  <= 1'b0;
            srw_r   <= 1'b0;
            sbit_r  <= 3'h0;
            saddr_r <= 6'h00;
            ssh_r   <= 7'h00;
        end else begin
            ssh_r  <= {ssh_r[5:0], SERIAL_IN_LINE};
            sbit_r <= sbit_r + 3'h1;
            if (sbit_r == 3'h7) begin
                if (!scmd_r) begin
                    scmd_r  <= 1'b1;
                    srw_r   <= ssh_r[6];
                    saddr_r <= {ssh_r[4:0], SERIAL_IN_LINE};
                end else begin
                    saddr_r <= saddr_r + 6'h01;
                end
            end
        end
    end

    // Write hand-off: needs about five core cycles per byte
    always_ff @(posedge SCL_SCK or negedge RST_N) begin
        if (!RST_N) begin
            swa_r   <= 6'h00;
            swd_r   <= BYTE_ZERO;
            swtgl_r <= 1'b0;
        end else if (post_wr) begin
            swa_r   <= saddr_r;
            swd_r   <= {ssh_r, SERIAL_IN_LINE};
            swtgl_r <= ~swtgl_r;
        end
    end

    always_ff @(negedge SCL_SCK or negedge spi_clr_n) begin
        if (!spi_clr_n)
            SERIAL_OUT_LINE <= 1'b0;
        else if (scmd_r && srw_r)
            SERIAL_OUT_LINE <= snap_r[map_idx({2'h0, saddr_r})]
                               [3'h7 - sbit_r];
        else
            SERIAL_OUT_LINE <= 1'b0;
    end

    // ==========================================================
    // Assertions
    logic [27:0] hlen_r;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            hlen_r <= '0;
        else
            hlen_r <= (ms_r == MS_IDLE) ? 28'h0 : hlen_r + 28'h1;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_sda_mode;
        SDA_OE |-> cs_st_r;
    endproperty
    a_sda_mode: assert property (p_sda_mode)
        else $error("SDA driven outside I2C mode");
    property p_int_high;
        (ctl_a_r[CTLA_INT_EN] && m_done_r) |=> (INT_O && INT_OE);
    endproperty
    a_int_high: assert property (p_int_high)
        else $error("Event pin not high with pending done");
    property p_int_hiz;
        (!ctl_a_r[CTLA_INT_EN]) [*2] |-> (!INT_OE && !INT_O);
    endproperty
    a_int_hiz: assert property (p_int_hiz)
        else $error("Event pin driven while disabled");
    property p_addr_match;
        ($rose(sda_oe_r) && $past(i2c_st_r == I_ADDR))
            |-> $past(ish_r[7:1]) == SLAVE_ADDR;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("Acknowledged a foreign address");
    property p_sda_scl_low;
        $changed(sda_oe_r)
            |-> $past(!scl_st_r || i2c_start || i2c_stop || !cs_st_r);
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("SDA changed while SCL high");
    property p_open_drain;
        !SDA_O;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("SDA driven high");
    property p_packed;
        (m_end && !bw16) |=> (img[ADDR_X_HI[3:0]] == $past(X_RESULT[17:10])
            && img[ADDR_LOW_BITS[3:0]][7:6] == $past(X_RESULT[1:0]));
    endproperty
    a_packed: assert property (p_packed)
        else $error("Axis result split wrongly");
    property p_meas_time;
        ($fell(ms_r == MS_MAG) && bw16)
            |-> ($past(hlen_r) == 28'(MEAS_CYC - 1)) && m_done_r;
    endproperty
    a_meas_time: assert property (p_meas_time)
        else $error("16-bit measurement time wrong");
    property p_w1c;
        (stat_w1c && wr_data[STAT_MEAS_M] && !m_end) |=> !m_done_r;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Done flag not cleared by write of 1");
    property p_reg_ptr;
        (i2c_st_r == I_RX && scl_fall && ibit_r == 4'h8 && ifirst_r
            && !i2c_start && !i2c_stop && i2c_on)
            |=> iptr_r == $past(ish_r);
    endproperty
    a_reg_ptr: assert property (p_reg_ptr)
        else $error("First I2C byte not taken as address");
    property p_spi_post;
        @(posedge SCL_SCK) disable iff (!RST_N)
        $changed(swtgl_r) |-> $past(scmd_r && !srw_r && sbit_r == 3'h7);
    endproperty
    a_spi_post: assert property (p_spi_post)
        else $error("Serial write posted off a byte boundary");

    c_meas_done: cover property (m_end);
    c_i2c_ack:   cover property ($rose(sda_oe_r) && i2c_st_r == I_AACK);
    c_spi_write: cover property (wev);
    c_int_rise:  cover property ($rose(INT_O));

endmodule : mag_host_regs

// [spi_host_model.sv]
// Host master model for the four-wire serial port
`timescale 1ns/1ns
module spi_host_model (
    // Serial pins
    output logic       sck,
    output logic       cs_n,
    output logic       sdi,
    input  wire logic  sdo,
    input  wire logic  sda,
    // Read results
    output logic [7:0] rd_byte,
    output logic       rd_stb
);
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b1;
        rd_byte = 8'h00;
        rd_stb = 1'b0;
    end

    // ==========================================================
    // One frame; clock runs only inside it, 15 ns per bit
    task automatic xfer(input logic rw, input logic [5:0] a,
                        input logic [7:0] wd, input int nb);
        logic [7:0] sh;
        sh = {rw, 1'b0, a};
        cs_n = 1'b0;
        #8;
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            sck = 1'b0;
            sdi = sh[7];
            #7;
            sck = 1'b1;
            rd_byte = {rd_byte[6:0], sdo};
            sh = {sh[6:0], ~sh[7]};
            if (i % 8 == 7) begin
                sh = wd;
                if (i > 8 && rw) rd_stb = ~rd_stb;
            end
            #8;
        end
        cs_n = 1'b1;
        // Stale data would hide a sampling slip
        sdi = ~sdi;
    endtask : xfer

    // ==========================================================
    // I2C master: 1 us per bit, data moved only while the clock is low
    task automatic i2c_byte(input logic [8:0] b, output logic ack);
        ack = 1'b1;
        for (int i = 8; i >= 0; i--) begin
            #100;
            sdi = b[i];
            #400;
            sck = 1'b1;
            #500;
            ack = sda;
            sck = 1'b0;
        end
    endtask : i2c_byte

    // Start, address, register, data, stop; the ninth bit of each
    // byte is released so that the acknowledge level comes back
    task automatic i2c_wr3(input logic [7:0] dv, input logic [7:0] ra,
                           input logic [7:0] wd, output logic [2:0] acks);
        sdi = 1'b1;
        #1000;
        sdi = 1'b0;
        #500;
        sck = 1'b0;
        i2c_byte({dv, 1'b1}, acks[2]);
        i2c_byte({ra, 1'b1}, acks[1]);
        i2c_byte({wd, 1'b1}, acks[0]);
        #100;
        sdi = 1'b0;
        #400;
        sck = 1'b1;
        #500;
        sdi = 1'b1;
        #500;
    endtask : i2c_wr3
endmodule : spi_host_model

// [mag_host_regs_tb.sv]
// Self-checking bench of the sensor host register port
`timescale 1ns/1ns
module mag_host_regs_tb;
    import mag_regs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sck, cs_n, sdi, sda_o, sda_oe, sdo;
    logic        int_o, int_oe, rd_stb;
    logic [2:0]  acks;
    logic [17:0] ax [3];
    logic [7:0]  tr, rd_byte;
    logic [7:0]  exp_q [$];
    int          seed = 84089;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #25 clk = ~clk;

    mag_host_regs #(.MEAS_CYC(64)) mag_host_regs_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .SCL_SCK(sck),
        .CHIP_SELECT_N(cs_n), .SERIAL_IN_LINE(sdi & ~sda_oe),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .SERIAL_OUT_LINE(sdo),
        .INT_O(int_o), .INT_OE(int_oe), .X_RESULT(ax[0]),
        .Y_RESULT(ax[1]), .Z_RESULT(ax[2]), .TEMP_RESULT(tr));
    spi_host_model spi_host_model_inst (
        .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sda(sdi & ~sda_oe),
        .rd_byte(rd_byte), .rd_stb(rd_stb));

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic acc(input logic rw, input logic [5:0] a,
                       input logic [7:0] d, input int n);
        @(negedge clk);
        spi_host_model_inst.xfer(rw, a, d, n);
        // Keeps posted writes well apart
        repeat (8) @(negedge clk);
    endtask : acc

    task automatic wait_int();
        for (int k = 0; k < 300 && int_o !== 1'b1; k++) begin
            @(negedge clk);
        end
    endtask : wait_int

    // ==========================================================
    // Results checker: oldest note against each read byte
    always @(rd_stb) begin
        if (exp_q.size() > 0) begin
            check("read byte", rd_byte, exp_q.pop_front());
        end
    end

    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 3; i++) ax[i] = 18'($random(seed));
        tr = 8'($random(seed));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("int_oe", {7'h0, int_oe}, 8'h00);
        acc(1'b0, 6'h0A, 8'h00, 1);
        acc(1'b0, 6'h09, 8'h05, 1);
        check("int_oe", {7'h0, int_oe}, 8'h01);
        repeat (30) @(negedge clk);
        check("early done", {7'h0, int_o}, 8'h00);
        wait_int();
        check("int_o", {7'h0, int_o}, 8'h01);
        exp_q.push_back(8'h11);
        acc(1'b1, 6'h08, 8'h00, 1);
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back(ax[i][17:10]);
            exp_q.push_back(ax[i][9:2]);
        end
        exp_q.push_back(8'h00);
        acc(1'b1, 6'h00, 8'h00, 7);
        acc(1'b0, 6'h08, 8'h01, 1);
        check("cleared", {7'h0, int_o}, 8'h00);
        acc(1'b0, 6'h0A, 8'h01, 1);
        acc(1'b0, 6'h09, 8'h05, 1);
        wait_int();
        exp_q.push_back({ax[0][1:0], ax[1][1:0], ax[2][1:0], 2'b00});
        exp_q.push_back(PART_ID_DEFAULT);
        exp_q.push_back(8'h00);
        acc(1'b1, 6'h06, 8'h00, 1);
        acc(1'b1, 6'h2F, 8'h00, 1);
        acc(1'b1, 6'h09, 8'h00, 1);
        // Temperature run: result and its done flag read as one burst
        acc(1'b0, 6'h08, 8'h01, 1);
        acc(1'b0, 6'h09, 8'h06, 1);
        wait_int();
        exp_q.push_back(tr);
        exp_q.push_back(8'h12);
        acc(1'b1, 6'h07, 8'h00, 2);
        // I2C: a foreign address is ignored, the own one writes 09H
        spi_host_model_inst.i2c_wr3({SLAVE_ADDR_DFLT ^ 7'h01, 1'b0},
                                    8'h09, 8'h00, acks);
        check("foreign ack", {5'h0, acks}, 8'h07);
        check("int_oe kept", {7'h0, int_oe}, 8'h01);
        spi_host_model_inst.i2c_wr3({SLAVE_ADDR_DFLT, 1'b0},
                                    8'h09, 8'h00, acks);
        check("own ack", {5'h0, acks}, 8'h00);
        check("int_oe off", {7'h0, int_oe}, 8'h00);
        check("sda_oe", {7'h0, sda_oe}, 8'h00);
        check("sda_o", {7'h0, sda_o}, 8'h00);
        check("pending", 8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule : mag_host_regs_tb
